// *** src/wake_line_map.vh ***
`ifndef WAKE_LINE_MAP_VH
`define WAKE_LINE_MAP_VH

// Register offsets
`define ADDR_WAKE_CONTROL 8'hF9
`define ADDR_WAKE_MASK_HIGH 8'hFA
`define ADDR_WAKE_MASK_LOW 8'hFB
`define ADDR_TRIGGER_POLARITY_HIGH 8'hFC
`define ADDR_TRIGGER_POLARITY_LOW 8'hFD
`define ADDR_LINE_PENDING_HIGH 8'hFE
`define ADDR_LINE_PENDING_LOW 8'hFF

// Field positions in wake_control
`define BIT_WAKE_MODE_SELECT 0
`define BIT_CHANNEL_SOURCE_SELECT 1
`define BIT_STOP 2

// Reset values
`define RST_BYTE 8'h00
`define RST_LINES 16'h0000
`define RST_STATE 3'h0

// Read value of unused control bits
`define CONTROL_UNUSED 5'h00

// Stop sequence states
`define ST_IDLE 3'h0
`define ST_GOT_ONE 3'h1
`define ST_GOT_ZERO 3'h2
`define ST_ARMED 3'h3
`define ST_STOPPED 3'h4

`endif

// *** src/wake_line_stop_control.v ***
// Contract
// - Stop requested by writing one, zero, one to the stop bit, three consecutive writes.
// - Accept only in wake mode, unmasked pending clear, some mask bit set.
// - Any other register write or acknowledge mid-sequence aborts; stop and exit read zero.
// - Stop bit reads one after first write and after successful third write.
// - Valid sequence sets stop bit and requests stop; exit leaves stop zero, flag one.
// - Unmasked wake-up event while stopped clears the stop bit in hardware.
// - Wake event during sequence prevents entry; stop and flag zero, pending stays set.
// - Exit flag stays set until software clears it; filtered requests leave it clear.
// - Stop request is ORed with the external active-low stop pin.
// - Source select picks dedicated pin at zero, the sixteen lines at one.
// - Wake mode bit selects interrupt role at zero, wake-up role at one; readable.
// - Masked pending line raises interrupt when source one, wake event when mode one.
// - Masked-off line never wakes; source zero means only the dedicated pin drives channel.
// - Channel recognises rising edges of the OR of unmasked pending lines.
// - Clearing one pending bit with another left gives a fresh rising edge.
// - Any single unmasked line event ends deep-stop.
// - Pending bits are edge captured; clearing works while the line stays active.
// - Polarity zero captures falling edges, one captures rising edges, per line.
// - Hardware sets pending on trigger edge; software clears it and may set it.
`include "wake_line_map.vh"
`default_nettype none

module wake_line_stop_control (
  input wire core_clk_in,
  input wire arst_n_in,
  input wire [7:0] reg_addr_in,
  input wire reg_wr_in,
  input wire [7:0] reg_wdata_in,
  input wire reg_rd_in,
  output reg [7:0] reg_rdata_out,
  input wire ack_in,
  input wire [15:0] wake_lines_in,
  input wire dedicated_ext_irq_pin_in,
  input wire stop_pin_n_in,
  input wire stop_entered_in,
  input wire exit_flag_clear_in,
  output wire stop_request_out,
  output reg stop_exit_flag_out,
  output reg shared_ext_irq_channel_out,
  output wire channel_rise_out,
  output wire wake_event_out,
  output wire wake_async_out
);

  // Reset release synchroniser
  reg rst_meta_n;
  reg rst_n;

  always @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rst_meta_n <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_n <= rst_meta_n;
    end
  end

  // Register state
  reg wake_mode_select;
  reg channel_source_select;
  reg [15:0] line_mask;
  reg [15:0] trigger_polarity;
  reg [15:0] line_pending;
  reg [2:0] state;
  reg [2:0] next_state;
  reg next_exit_flag;

  // Pin synchronisers
  reg [15:0] line_meta;
  reg [15:0] line_sync;
  reg [15:0] line_prev;
  reg pin_meta;
  reg pin_sync;
  reg stop_meta_n;
  reg stop_sync_n;

  always @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      line_meta <= `RST_LINES;
      line_sync <= `RST_LINES;
      line_prev <= `RST_LINES;
      pin_meta <= 1'b0;
      pin_sync <= 1'b0;
      stop_meta_n <= 1'b1;
      stop_sync_n <= 1'b1;
    end else begin
      line_meta <= wake_lines_in;
      line_sync <= line_meta;
      line_prev <= line_sync;
      pin_meta <= dedicated_ext_irq_pin_in;
      pin_sync <= pin_meta;
      stop_meta_n <= stop_pin_n_in;
      stop_sync_n <= stop_meta_n;
    end
  end

  // Write decode
  wire wr_control = reg_wr_in && (reg_addr_in == `ADDR_WAKE_CONTROL);
  wire wr_mask_high = reg_wr_in && (reg_addr_in == `ADDR_WAKE_MASK_HIGH);
  wire wr_mask_low = reg_wr_in && (reg_addr_in == `ADDR_WAKE_MASK_LOW);
  wire wr_pol_high = reg_wr_in && (reg_addr_in == `ADDR_TRIGGER_POLARITY_HIGH);
  wire wr_pol_low = reg_wr_in && (reg_addr_in == `ADDR_TRIGGER_POLARITY_LOW);
  wire wr_pend_high = reg_wr_in && (reg_addr_in == `ADDR_LINE_PENDING_HIGH);
  wire wr_pend_low = reg_wr_in && (reg_addr_in == `ADDR_LINE_PENDING_LOW);
  wire wr_other = (reg_wr_in && !wr_control) || ack_in;
  wire stop_wdata = reg_wdata_in[`BIT_STOP];

  // Edge capture per line
  wire [15:0] rise = line_sync & ~line_prev;
  wire [15:0] fall = ~line_sync & line_prev;
  wire [15:0] edge_hit = (trigger_polarity & rise) | (~trigger_polarity & fall);
  // Edges on the eight lines whose polarity byte is being rewritten are dropped, since the old
  // and new trigger sense disagree in that cycle
  wire [15:0] pol_block = {{8{wr_pol_high}}, {8{wr_pol_low}}};
  wire [15:0] hw_set = edge_hit & ~pol_block;

  always @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      line_pending <= `RST_LINES;
    end else begin
      // Set wins over a software clear in the same cycle
      if (wr_pend_high) begin
        line_pending[15:8] <= reg_wdata_in | hw_set[15:8];
      end else begin
        line_pending[15:8] <= line_pending[15:8] | hw_set[15:8];
      end
      if (wr_pend_low) begin
        line_pending[7:0] <= reg_wdata_in | hw_set[7:0];
      end else begin
        line_pending[7:0] <= line_pending[7:0] | hw_set[7:0];
      end
    end
  end

  always @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      line_mask <= `RST_LINES;
      trigger_polarity <= `RST_LINES;
      wake_mode_select <= 1'b0;
      channel_source_select <= 1'b0;
    end else begin
      if (wr_mask_high) begin
        line_mask[15:8] <= reg_wdata_in;
      end
      if (wr_mask_low) begin
        line_mask[7:0] <= reg_wdata_in;
      end
      if (wr_pol_high) begin
        trigger_polarity[15:8] <= reg_wdata_in;
      end
      if (wr_pol_low) begin
        trigger_polarity[7:0] <= reg_wdata_in;
      end
      if (wr_control) begin
        wake_mode_select <= reg_wdata_in[`BIT_WAKE_MODE_SELECT];
        channel_source_select <= reg_wdata_in[`BIT_CHANNEL_SOURCE_SELECT];
      end
    end
  end

  // Line combination
  wire [15:0] masked_pending = line_pending & line_mask;
  wire any_masked = |masked_pending;
  wire any_mask = |line_mask;
  wire lines_irq = channel_source_select & any_masked;
  assign wake_event_out = wake_mode_select & any_masked;

  // Level path that needs no clock, for the clock unit while stopped
  wire [15:0] line_active = (trigger_polarity & wake_lines_in) | (~trigger_polarity & ~wake_lines_in);
  assign wake_async_out = (state == `ST_STOPPED) && wake_mode_select && |(line_mask & line_active);

  // A clear that leaves other masked bits pending drops the channel for one
  // cycle, so the receiver sees a new rising edge
  wire [15:0] pend_clear = {{8{wr_pend_high}} & ~reg_wdata_in & line_pending[15:8],
                            {8{wr_pend_low}} & ~reg_wdata_in & line_pending[7:0]};
  reg clear_dip;
  reg channel_prev;

  always @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      clear_dip <= 1'b0;
    end else begin
      clear_dip <= |(pend_clear & line_mask);
    end
  end

  always @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      shared_ext_irq_channel_out <= 1'b0;
      channel_prev <= 1'b0;
    end else begin
      if (channel_source_select) begin
        shared_ext_irq_channel_out <= lines_irq & ~clear_dip;
      end else begin
        shared_ext_irq_channel_out <= pin_sync;
      end
      channel_prev <= shared_ext_irq_channel_out;
    end
  end

  assign channel_rise_out = shared_ext_irq_channel_out & ~channel_prev;

  // Stop sequence
  wire stop_allowed = wake_mode_select && !any_masked && any_mask;
  wire new_masked_event = |(hw_set & line_mask);

  always @* begin
    next_state = state;
    next_exit_flag = stop_exit_flag_out;
    case (state)
      `ST_IDLE: begin
        if (wr_control && stop_wdata && !ack_in) begin
          next_state = `ST_GOT_ONE;
        end
      end
      `ST_GOT_ONE: begin
        if (wr_other) begin
          next_state = `ST_IDLE;
        end else if (new_masked_event) begin
          next_state = `ST_IDLE;
        end else if (wr_control && !stop_wdata) begin
          next_state = `ST_GOT_ZERO;
        end
      end
      `ST_GOT_ZERO: begin
        if (wr_other) begin
          next_state = `ST_IDLE;
        end else if (new_masked_event) begin
          next_state = `ST_IDLE;
        end else if (wr_control && stop_wdata) begin
          // Mode bit is judged from the value being written with the third write
          if (reg_wdata_in[`BIT_WAKE_MODE_SELECT] && !any_masked && any_mask) begin
            next_state = `ST_ARMED;
          end else begin
            next_state = `ST_IDLE;
          end
        end else if (wr_control) begin
          next_state = `ST_IDLE;
        end
      end
      `ST_ARMED: begin
        // Clock unit needs a few cycles; a write in that gap cancels entry
        if (wr_other || wr_control) begin
          next_state = `ST_IDLE;
        end else if (new_masked_event || !stop_allowed) begin
          next_state = `ST_IDLE;
        end else if (stop_entered_in) begin
          next_state = `ST_STOPPED;
        end
      end
      `ST_STOPPED: begin
        if (wake_event_out) begin
          next_state = `ST_IDLE;
          next_exit_flag = 1'b1;
        end
      end
      default: begin
        next_state = `ST_IDLE;
      end
    endcase
    // Software clear loses to a simultaneous exit
    if (exit_flag_clear_in && !(state == `ST_STOPPED && wake_event_out)) begin
      next_exit_flag = 1'b0;
    end
  end

  always @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      state <= `RST_STATE;
      stop_exit_flag_out <= 1'b0;
    end else begin
      state <= next_state;
      stop_exit_flag_out <= next_exit_flag;
    end
  end

  wire stop_bit = (state == `ST_GOT_ONE) || (state == `ST_ARMED) || (state == `ST_STOPPED);
  wire stop_from_block = (state == `ST_ARMED) || (state == `ST_STOPPED);
  assign stop_request_out = stop_from_block | ~stop_sync_n;

  // Read port
  reg [7:0] next_rdata;

  always @* begin
    next_rdata = `RST_BYTE;
    case (reg_addr_in)
      `ADDR_WAKE_CONTROL: begin
        next_rdata = {`CONTROL_UNUSED, stop_bit, channel_source_select, wake_mode_select};
      end
      `ADDR_WAKE_MASK_HIGH: begin
        next_rdata = line_mask[15:8];
      end
      `ADDR_WAKE_MASK_LOW: begin
        next_rdata = line_mask[7:0];
      end
      `ADDR_TRIGGER_POLARITY_HIGH: begin
        next_rdata = trigger_polarity[15:8];
      end
      `ADDR_TRIGGER_POLARITY_LOW: begin
        next_rdata = trigger_polarity[7:0];
      end
      `ADDR_LINE_PENDING_HIGH: begin
        next_rdata = line_pending[15:8];
      end
      `ADDR_LINE_PENDING_LOW: begin
        next_rdata = line_pending[7:0];
      end
      default: begin
        next_rdata = `RST_BYTE;
      end
    endcase
  end

  always @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_out <= `RST_BYTE;
    end else if (reg_rd_in) begin
      reg_rdata_out <= next_rdata;
    end
  end

endmodule

`default_nettype wire

// *** verif/wake_line_props.sv ***
`default_nettype none
module wake_line_props (
  input wire logic core_clk_in,
  input wire logic arst_n_in,
  input wire logic reg_wr_in,
  input wire logic ack_in,
  input wire logic stop_pin_n_in,
  input wire logic stop_entered_in,
  input wire logic exit_flag_clear_in,
  input wire logic stop_request_out,
  input wire logic stop_exit_flag_out,
  input wire logic shared_ext_irq_channel_out,
  input wire logic channel_rise_out,
  input wire logic wake_event_out,
  input wire logic wake_async_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!arst_n_in);
  // Pin passes a two-stage synchroniser, so four samples cover it
  sequence pin_low; !stop_pin_n_in [*4]; endsequence
  sequence pin_quiet; stop_pin_n_in [*4]; endsequence
  sequence armed_wait; stop_request_out && !stop_entered_in; endsequence
  pin_forces_stop_a: assert property (pin_low |-> stop_request_out) else $error("pin stop lost");
  rise_on_edge_a: assert property (channel_rise_out |-> shared_ext_irq_channel_out &&
    !$past(shared_ext_irq_channel_out)) else $error("rise without edge");
  flag_sticky_a: assert property (stop_exit_flag_out && !exit_flag_clear_in |=> stop_exit_flag_out)
    else $error("exit flag dropped");
  flag_clear_a: assert property (exit_flag_clear_in && !wake_event_out |=> !stop_exit_flag_out)
    else $error("exit flag kept");
  flag_cause_a: assert property ($rose(stop_exit_flag_out) |-> $past(wake_event_out))
    else $error("exit without wake");
  wake_release_a: assert property (pin_quiet ##0 $rose(stop_exit_flag_out) |-> !stop_request_out)
    else $error("stop held after wake");
  ack_abort_a: assert property (pin_quiet ##0 armed_wait ##0 ack_in |=> !stop_request_out)
    else $error("ack kept stop");
  write_abort_a: assert property (pin_quiet ##0 armed_wait ##0 reg_wr_in |=> !stop_request_out)
    else $error("write kept stop");
  req_cause_a: assert property ($rose(stop_request_out) |-> $past(reg_wr_in) || !$past(stop_pin_n_in, 2))
    else $error("stop without cause");
  // The clockless wake path may only speak while the block holds stop
  async_in_stop_a: assert property (wake_async_out |-> stop_request_out)
    else $error("async wake outside stop");
endmodule
bind wake_line_stop_control wake_line_props u_props (.core_clk_in, .arst_n_in, .reg_wr_in, .ack_in,
  .stop_pin_n_in, .stop_entered_in, .exit_flag_clear_in, .stop_request_out, .stop_exit_flag_out,
  .shared_ext_irq_channel_out, .channel_rise_out, .wake_event_out, .wake_async_out);
`default_nettype wire

// *** verif/wake_partner.sv ***
`default_nettype none
module wake_partner (
  input wire logic clk_in,
  input wire logic stop_req_in,
  input wire logic [4:0] lag_in,
  input wire logic poke_in,
  input wire logic [3:0] idx_in,
  output logic [15:0] lines_out,
  output logic entered_out
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt = 0;
  initial lines_out = 16'h0000;
  initial entered_out = 1'b0;
  // Clock unit needs a few cycles to stop; a long lag opens the cancel window
  always @(posedge clk_in) begin
    cnt <= stop_req_in ? cnt + 1 : 0;
    entered_out <= stop_req_in && cnt >= lag_in;
    if (poke_in)
      lines_out <= lines_out ^ (16'h0001 << idx_in);
  end
endmodule
`default_nettype wire

// *** verif/testbench.sv ***
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst_n = 0, wr = 0, rd = 0, ack = 0, pin = 0, pin_n = 1, clr = 0, poke = 0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, lf = 8'h13;
  logic [4:0] lag = 5'd2;
  logic [15:0] lines;
  logic req, entered, flag, chan, rise;
  logic [7:0] m [0:255];
  int bad_count = 0, tests_run = 0, cyc = 0, rises = 0;
  initial forever #20 clk = ~clk;
  wake_line_stop_control DUT (.core_clk_in(clk), .arst_n_in(rst_n), .reg_addr_in(addr), .reg_wr_in(wr),
    .reg_wdata_in(wdata), .reg_rd_in(rd), .reg_rdata_out(rdata), .ack_in(ack), .wake_lines_in(lines),
    .dedicated_ext_irq_pin_in(pin), .stop_pin_n_in(pin_n), .stop_entered_in(entered),
    .exit_flag_clear_in(clr), .stop_request_out(req), .stop_exit_flag_out(flag),
    .shared_ext_irq_channel_out(chan), .channel_rise_out(rise), .wake_event_out(), .wake_async_out());
  wake_partner far (.clk_in(clk), .stop_req_in(req), .lag_in(lag), .poke_in(poke), .idx_in(4'h0),
    .lines_out(lines), .entered_out(entered));
  function automatic logic [7:0] nxt(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  task automatic results;
    $display("tests %0d wrong %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    tests_run++;
    if (s !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) begin
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
    end
    @(posedge clk) wr <= 1'b0;
    m[a] = d;
  endtask
  task automatic rd_chk(input logic [7:0] a);
    @(posedge clk) begin
      addr <= a;
      rd <= 1'b1;
    end
    @(posedge clk) rd <= 1'b0;
    @(negedge clk) chk("reg", m[a], rdata);
  endtask
  // Refused sequences leave only the mode and source bits behind
  task automatic seq3(input logic [7:0] c);
    wr_reg(8'hF9, c | 8'h04);
    wr_reg(8'hF9, c);
    wr_reg(8'hF9, c | 8'h04);
    m[8'hF9] = c;
  endtask
  task automatic strobe(input logic p, input logic a, input logic c);
    @(posedge clk) begin
      poke <= p;
      ack <= a;
      clr <= c;
    end
    @(posedge clk) begin
      poke <= 1'b0;
      ack <= 1'b0;
      clr <= 1'b0;
    end
  endtask
  always @(posedge clk) begin
    cyc++;
    if (rise === 1'b1)
      rises++;
    if (cyc > 6000) begin
      bad_count++;
      results();
    end
  end
  initial begin
    m = '{default: 8'h00};
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    for (int a = 249; a < 256; a++)
      rd_chk(a[7:0]);
    rd_chk(8'h10);
    for (int a = 250; a < 254; a++) begin
      lf = nxt(lf);
      wr_reg(a[7:0], lf);
      rd_chk(a[7:0]);
    end
    // Rising-edge capture everywhere, only the low eight lines unmasked
    wr_reg(8'hFC, 8'hFF);
    wr_reg(8'hFD, 8'hFF);
    wr_reg(8'hFA, 8'h00);
    wr_reg(8'hFB, 8'hFF);
    wr_reg(8'hF9, 8'h02);
    lf = nxt(lf);
    wr_reg(8'hFF, lf | 8'h01);
    rd_chk(8'hFF);
    idle(3);
    chk("chan", 8'h01, {7'h00, chan});
    wr_reg(8'hFF, 8'h03);
    idle(6);
    rises = 0;
    wr_reg(8'hFF, 8'h02);
    idle(6);
    chk("rises", 8'h01, rises[7:0]);
    wr_reg(8'hFF, 8'h01);
    wr_reg(8'hF9, 8'h00);
    idle(4);
    chk("chan", 8'h00, {7'h00, chan});
    @(posedge clk) pin <= 1'b1;
    idle(4);
    chk("chan", 8'h01, {7'h00, chan});
    @(posedge clk) pin <= 1'b0;
    wr_reg(8'hFF, 8'h00);
    wr_reg(8'hFB, 8'h01);
    wr_reg(8'hF9, 8'h05);
    rd_chk(8'hF9);
    wr_reg(8'hF9, 8'h01);
    rd_chk(8'hF9);
    wr_reg(8'hF9, 8'h05);
    rd_chk(8'hF9);
    for (int i = 0; i < 40 && entered !== 1'b1; i++)
      @(posedge clk);
    chk("req", 8'h01, {7'h00, req});
    strobe(1'b1, 1'b0, 1'b0);
    for (int i = 0; i < 40 && flag !== 1'b1; i++)
      @(posedge clk);
    idle(1);
    chk("flag", 8'h01, {7'h00, flag});
    chk("req", 8'h00, {7'h00, req});
    m[8'hF9] = 8'h01;
    rd_chk(8'hF9);
    m[8'hFF] = 8'h01;
    rd_chk(8'hFF);
    wr_reg(8'hFF, 8'h00);
    rd_chk(8'hFF);
    chk("flag", 8'h01, {7'h00, flag});
    strobe(1'b0, 1'b0, 1'b1);
    idle(1);
    chk("flag", 8'h00, {7'h00, flag});
    strobe(1'b1, 1'b0, 1'b0);
    @(posedge clk) lag <= 5'd20;
    seq3(8'h01);
    wr_reg(8'hFA, 8'h00);
    idle(1);
    chk("req", 8'h00, {7'h00, req});
    rd_chk(8'hF9);
    seq3(8'h01);
    strobe(1'b0, 1'b1, 1'b0);
    idle(1);
    chk("req", 8'h00, {7'h00, req});
    rd_chk(8'hF9);
    wr_reg(8'hF9, 8'h05);
    wr_reg(8'hF9, 8'h01);
    wr_reg(8'hFA, 8'h00);
    rd_chk(8'hF9);
    seq3(8'h01);
    strobe(1'b1, 1'b0, 1'b0);
    idle(6);
    chk("req", 8'h00, {7'h00, req});
    rd_chk(8'hF9);
    m[8'hFF] = 8'h01;
    rd_chk(8'hFF);
    chk("flag", 8'h00, {7'h00, flag});
    strobe(1'b1, 1'b0, 1'b0);
    seq3(8'h01);
    idle(3);
    chk("req", 8'h00, {7'h00, req});
    wr_reg(8'hFF, 8'h00);
    wr_reg(8'hFB, 8'h00);
    seq3(8'h01);
    idle(3);
    chk("req", 8'h00, {7'h00, req});
    wr_reg(8'hFB, 8'h01);
    seq3(8'h00);
    rd_chk(8'hF9);
    @(posedge clk) pin_n <= 1'b0;
    idle(4);
    chk("req", 8'h01, {7'h00, req});
    @(posedge clk) pin_n <= 1'b1;
    idle(4);
    chk("req", 8'h00, {7'h00, req});
    results();
  end
endmodule
`default_nettype wire
